// file: qbm_pkg.sv
package qbm_pkg;
  // Register byte addresses
  localparam logic [31:0] OFF_BUS_CTRL = 32'h0c00_0000;
  localparam logic [31:0] OFF_MODE     = 32'h0c00_0004;
  // Bus-control strobe positions
  localparam int B_REL    = 4;
  localparam int B_ASSERT = 3;
  localparam int B_FOUR   = 2;
  localparam int B_TWO    = 1;
  localparam int B_ONE    = 0;
  // Mode-control field positions
  localparam int B_WIDE   = 13;
  localparam int B_SPLIT  = 12;
  localparam int B_DLY_HI = 11;
  localparam int B_DLY_LO = 9;
  localparam int B_PIPE   = 8;
  localparam int B_NEG    = 7;
  localparam int B_AUTO   = 0;
  localparam logic [31:0] MODE_MASK = 32'h0000_3f81;
  localparam logic [31:0] MODE_RST  = 32'h0000_0000;
  // Lane widths
  localparam logic [1:0] LANE_ONE  = 2'h0;
  localparam logic [1:0] LANE_TWO  = 2'h1;
  localparam logic [1:0] LANE_FOUR = 2'h2;
  // Serial clock periods in link clock cycles; field lengths in bits
  localparam int SCK_HALF_CYC = 8;
  localparam int SCK_PER_CYC  = 2 * SCK_HALF_CYC;
  localparam logic [5:0] DUMMY_BITS       = 6'h08;
  localparam logic [5:0] ADDR_BITS_NARROW = 6'h20;
  localparam logic [5:0] ADDR_BITS_WIDE   = 6'h28;
  localparam logic [5:0] WORD_BITS        = 6'h20;
  localparam logic [7:0] READ_CMD         = 8'h0b;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_OUT   = 3'b001,
    S_DUMMY = 3'b010,
    S_IN    = 3'b011,
    S_END   = 3'b100
  } qbm_state_t;
endpackage

// file: qbm_fifo_if.sv
`timescale 1ns/1ps
interface qbm_fifo_if #(parameter int W = 32);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;
  modport prod (output wr_valid, output wr_data, input wr_ready);
  modport cons (input rd_valid, input rd_data, output rd_ready);
  modport fifo (input wr_valid, input wr_data, output wr_ready,
                output rd_valid, output rd_data, input rd_ready);
endinterface

// file: qbm_fifo.sv
`timescale 1ns/1ps
module qbm_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 4
) (
  input wire logic wclk,
  input wire logic wrst_n,
  input wire logic rclk,
  input wire logic rrst_n,
  qbm_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_chk
    $error("qbm_fifo: DEPTH must be a power of two of at least 4");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wbin_q, wbin_d, wgray_q, wgray_d;
  logic [AW:0]  rbin_q, rbin_d, rgray_q, rgray_d;
  logic [AW:0]  rg_w1_q, rg_w2_q, wg_r1_q, wg_r2_q;
  logic         push, pop;

  // Gray pointers cross; full compares top two bits inverted
  assign f.wr_ready = !(wgray_q == {~rg_w2_q[AW:AW-1], rg_w2_q[AW-2:0]});
  assign f.rd_valid = !(rgray_q == wg_r2_q);
  assign f.rd_data  = mem[rbin_q[AW-1:0]];
  assign push = f.wr_valid && f.wr_ready;
  assign pop  = f.rd_valid && f.rd_ready;

  always_comb begin
    wbin_d  = push ? wbin_q + 1'b1 : wbin_q;
    wgray_d = wbin_d ^ (wbin_d >> 1);
    rbin_d  = pop ? rbin_q + 1'b1 : rbin_q;
    rgray_d = rbin_d ^ (rbin_d >> 1);
  end

  always_ff @(posedge wclk) begin
    if (push) begin
      mem[wbin_q[AW-1:0]] <= f.wr_data;
    end
  end

  always_ff @(posedge wclk or negedge wrst_n) begin
    if (!wrst_n) begin
      wbin_q  <= '0;
      wgray_q <= '0;
      rg_w1_q <= '0;
      rg_w2_q <= '0;
    end else begin
      wbin_q  <= wbin_d;
      wgray_q <= wgray_d;
      rg_w1_q <= rgray_q;
      rg_w2_q <= rg_w1_q;
    end
  end

  always_ff @(posedge rclk or negedge rrst_n) begin
    if (!rrst_n) begin
      rbin_q  <= '0;
      rgray_q <= '0;
      wg_r1_q <= '0;
      wg_r2_q <= '0;
    end else begin
      rbin_q  <= rbin_d;
      rgray_q <= rgray_d;
      wg_r1_q <= wgray_q;
      wg_r2_q <= wg_r1_q;
    end
  end
endmodule

// file: qbm_ctrl.sv
`timescale 1ns/1ps
module qbm_ctrl #(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clk_link,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output      logic [31:0] reg_rdata,
  input  wire logic        rd_req_valid,
  output      logic        rd_req_ready,
  input  wire logic [31:0] rd_req_addr,
  input  wire logic [3:0]  rd_req_len,
  output      logic        rd_data_valid,
  input  wire logic        rd_data_ready,
  output      logic [31:0] rd_data,
  output      logic        flash_sel_n,
  output      logic        flash_sck,
  input  wire logic [3:0]  flash_io_in,
  output      logic [3:0]  flash_io_out,
  output      logic [3:0]  flash_io_oe
);
  import qbm_pkg::*;

  localparam logic [3:0] PH_LAST = 4'(SCK_PER_CYC - 1);
  localparam logic [3:0] PH_HALF = 4'(SCK_HALF_CYC);

  if (SCK_HALF_CYC < 8 || SCK_PER_CYC > 16) begin : g_chk
    $error("qbm_ctrl: serial half period must be 8 link cycles");
  end

  // Link-side state, declared ahead of its first use
  logic        lr1_q, lrst_n;
  logic        req_s1_q, req_s2_q, req_s3_q;
  logic [8:0]  cfg1_q, cfg_q;
  logic [3:0]  io1_q, io_q;
  qbm_state_t  state_q, state_d;
  logic [3:0]  ph_q, ph_d, ph_nx;
  logic [4:0]  cap_ph;
  logic [39:0] sh_q, sh_d;
  logic [5:0]  bits_q, bits_d, wbits_q, wbits_d, lane_n;
  logic [31:0] word_q, word_d, nxt_word, wdata_q, wdata_d, addr_q, addr_d;
  logic [4:0]  beats_q, beats_d;
  logic        cs_n_q, cs_n_d, sck_q, sck_d, done_tgl_q, done_tgl_d;
  logic        wvalid_q, wvalid_d, stall, cap, word_done, load;
  logic        first_q, first_d;
  logic [3:0]  oe_q, oe_d;

  qbm_fifo_if #(.W(32)) f ();

  qbm_fifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .wclk   (clk_link),
    .wrst_n (lrst_n),
    .rclk   (clk_sys),
    .rrst_n (rst_n),
    .f      (f.fifo)
  );

  // ---------------- System clock side ----------------
  logic        man_cs_n_q, man_cs_n_d;
  logic [1:0]  lane_q, lane_d;
  logic [31:0] mode_q, mode_d;
  logic [31:0] rdata_q, rdata_d;
  logic        busy_q, busy_d;
  logic        req_tgl_q, req_tgl_d;
  logic [31:0] req_addr_q, req_addr_d;
  logic [3:0]  req_len_q, req_len_d;
  logic        done_s1_q, done_s2_q, done_s3_q;
  logic        ctrl_wr, mode_wr, req_take;

  assign ctrl_wr      = reg_wr && (reg_addr == OFF_BUS_CTRL);
  assign mode_wr      = reg_wr && (reg_addr == OFF_MODE);
  assign rd_req_ready = mode_q[B_AUTO] && !busy_q;
  assign req_take     = rd_req_valid && rd_req_ready;
  assign reg_rdata    = rdata_q;
  assign rd_data      = f.rd_data;
  assign rd_data_valid = f.rd_valid;
  assign f.rd_ready   = rd_data_ready;

  always_comb begin
    man_cs_n_d = man_cs_n_q;
    lane_d     = lane_q;
    mode_d     = mode_q;
    rdata_d    = rdata_q;
    busy_d     = busy_q;
    req_tgl_d  = req_tgl_q;
    req_addr_d = req_addr_q;
    req_len_d  = req_len_q;
    if (ctrl_wr && !mode_q[B_AUTO]) begin
      if (reg_wdata[B_REL]) begin
        man_cs_n_d = 1'b1;
      end else if (reg_wdata[B_ASSERT]) begin
        man_cs_n_d = 1'b0;
      end
      if (reg_wdata[B_FOUR]) begin
        lane_d = LANE_FOUR;
      end else if (reg_wdata[B_TWO]) begin
        lane_d = LANE_TWO;
      end else if (reg_wdata[B_ONE]) begin
        lane_d = LANE_ONE;
      end
    end
    if (mode_wr) begin
      mode_d = reg_wdata & MODE_MASK;
    end
    if (reg_rd) begin
      rdata_d = (reg_addr == OFF_MODE) ? mode_q : 32'h0;
    end
    if (done_s2_q != done_s3_q) begin
      busy_d = 1'b0;
    end
    if (req_take) begin
      busy_d     = 1'b1;
      req_tgl_d  = ~req_tgl_q;
      req_addr_d = rd_req_addr;
      req_len_d  = rd_req_len;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      man_cs_n_q <= 1'b1;
      lane_q     <= LANE_ONE;
      mode_q     <= MODE_RST;
      rdata_q    <= 32'h0;
      busy_q     <= 1'b0;
      req_tgl_q  <= 1'b0;
      req_addr_q <= 32'h0;
      req_len_q  <= 4'h0;
      done_s1_q  <= 1'b0;
      done_s2_q  <= 1'b0;
      done_s3_q  <= 1'b0;
    end else begin
      man_cs_n_q <= man_cs_n_d;
      lane_q     <= lane_d;
      mode_q     <= mode_d;
      rdata_q    <= rdata_d;
      busy_q     <= busy_d;
      req_tgl_q  <= req_tgl_d;
      req_addr_q <= req_addr_d;
      req_len_q  <= req_len_d;
      done_s1_q  <= done_tgl_q;
      done_s2_q  <= done_s1_q;
      done_s3_q  <= done_s2_q;
    end
  end

  // Select pin follows the manual strobes or the auto sequencer
  assign flash_sel_n = mode_q[B_AUTO] ? cs_n_q : man_cs_n_q;

  // ---------------- Link clock side ----------------
  // Config levels are quasi-static; two flops carry them over
  always_ff @(posedge clk_link or negedge rst_n) begin
    if (!rst_n) begin
      lr1_q    <= 1'b0;
      lrst_n   <= 1'b0;
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      cfg1_q   <= 9'h0;
      cfg_q    <= 9'h0;
      io1_q    <= 4'h0;
      io_q     <= 4'h0;
    end else begin
      lr1_q    <= 1'b1;
      lrst_n   <= lr1_q;
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      cfg1_q   <= {lane_q, mode_q[B_WIDE:B_NEG]};
      cfg_q    <= cfg1_q;
      io1_q    <= flash_io_in;
      io_q     <= io1_q;
    end
  end

  assign f.wr_valid   = wvalid_q;
  assign f.wr_data    = wdata_q;
  assign flash_sck    = sck_q;
  assign flash_io_out = {3'h0, sh_q[39]};
  assign flash_io_oe  = oe_q;

  always_comb begin
    unique case (cfg_q[8:7])
      LANE_FOUR: begin
        lane_n   = 6'h4;
        nxt_word = {word_q[27:0], io_q};
      end
      LANE_TWO: begin
        lane_n   = 6'h2;
        nxt_word = {word_q[29:0], io_q[1:0]};
      end
      default: begin
        lane_n   = 6'h1;
        nxt_word = {word_q[30:0], io_q[1]};
      end
    endcase
    // Phases from 16 up sample in the period after the bit was launched
    cap_ph = cfg_q[1] ? {2'b10, cfg_q[4:2]} : (cfg_q[0] ? 5'h10 : {1'b0, PH_HALF});
    ph_nx  = (ph_q == PH_LAST) ? 4'h0 : ph_q + 4'h1;
    // Stall with the clock high, so the bit in flight is not replaced
    stall  = (state_q == S_IN) && wvalid_q && !f.wr_ready && (ph_q == PH_LAST);
    cap    = (state_q == S_IN) && !stall && (ph_q == cap_ph[3:0]) &&
             !(cap_ph[4] && first_q);
    word_done = cap && (wbits_q == lane_n);
  end

  always_comb begin
    state_d    = state_q;
    ph_d       = ph_q;
    sh_d       = sh_q;
    bits_d     = bits_q;
    word_d     = word_q;
    wbits_d    = wbits_q;
    beats_d    = beats_q;
    addr_d     = addr_q;
    cs_n_d     = cs_n_q;
    first_d    = first_q;
    done_tgl_d = done_tgl_q;
    wdata_d    = wdata_q;
    wvalid_d   = wvalid_q && !f.wr_ready;
    load       = 1'b0;
    unique case (state_q)
      S_IDLE: begin
        ph_d = 4'h0;
        if (req_s2_q != req_s3_q) begin
          addr_d  = req_addr_q;
          beats_d = {1'b0, req_len_q} + 5'h1;
          load    = 1'b1;
        end
      end
      S_OUT: begin
        ph_d = ph_nx;
        if (ph_q == PH_LAST) begin
          sh_d   = {sh_q[38:0], 1'b0};
          bits_d = bits_q - 6'h1;
          if (bits_q == 6'h1) begin
            state_d = S_DUMMY;
            bits_d  = DUMMY_BITS;
          end
        end
      end
      S_DUMMY: begin
        ph_d = ph_nx;
        if (ph_q == PH_LAST) begin
          bits_d = bits_q - 6'h1;
          if (bits_q == 6'h1) begin
            state_d = S_IN;
            wbits_d = WORD_BITS;
            first_d = 1'b1;
          end
        end
      end
      S_IN: begin
        if (!stall) begin
          ph_d = ph_nx;
        end
        if (!stall && ph_q == PH_LAST) begin
          first_d = 1'b0;
        end
        if (cap) begin
          word_d  = nxt_word;
          wbits_d = wbits_q - lane_n;
        end
        if (word_done) begin
          wvalid_d = 1'b1;
          wdata_d  = nxt_word;
          wbits_d  = WORD_BITS;
          beats_d  = beats_q - 5'h1;
          addr_d   = addr_q + 32'h4;
          if (beats_q == 5'h1 || cfg_q[5]) begin
            state_d = S_END;
            ph_d    = 4'h0;
            cs_n_d  = 1'b1;
          end
        end
      end
      S_END: begin
        ph_d = ph_nx;
        if (ph_q == PH_LAST) begin
          if (beats_q == 5'h0) begin
            state_d    = S_IDLE;
            done_tgl_d = ~done_tgl_q;
          end else begin
            load = 1'b1;
          end
        end
      end
      default: state_d = S_IDLE;
    endcase
    if (load) begin
      state_d = S_OUT;
      cs_n_d  = 1'b0;
      ph_d    = 4'h0;
      sh_d    = cfg_q[6] ? {READ_CMD, addr_d} : {READ_CMD, addr_d[23:0], 8'h00};
      bits_d  = cfg_q[6] ? ADDR_BITS_WIDE : ADDR_BITS_NARROW;
    end
    sck_d = (state_d inside {S_OUT, S_DUMMY, S_IN}) && (ph_d >= PH_HALF);
    oe_d  = (state_d == S_OUT) ? 4'h1 : 4'h0;
  end

  always_ff @(posedge clk_link or negedge lrst_n) begin
    if (!lrst_n) begin
      state_q    <= S_IDLE;
      ph_q       <= 4'h0;
      sh_q       <= 40'h0;
      bits_q     <= 6'h0;
      word_q     <= 32'h0;
      wbits_q    <= 6'h0;
      beats_q    <= 5'h0;
      addr_q     <= 32'h0;
      cs_n_q     <= 1'b1;
      first_q    <= 1'b0;
      sck_q      <= 1'b0;
      done_tgl_q <= 1'b0;
      wdata_q    <= 32'h0;
      wvalid_q   <= 1'b0;
      oe_q       <= 4'h0;
    end else begin
      state_q    <= state_d;
      ph_q       <= ph_d;
      sh_q       <= sh_d;
      bits_q     <= bits_d;
      word_q     <= word_d;
      wbits_q    <= wbits_d;
      beats_q    <= beats_d;
      addr_q     <= addr_d;
      cs_n_q     <= cs_n_d;
      first_q    <= first_d;
      sck_q      <= sck_d;
      done_tgl_q <= done_tgl_d;
      wdata_q    <= wdata_d;
      wvalid_q   <= wvalid_d;
      oe_q       <= oe_d;
    end
  end

  // ---------------- Assertions ----------------
  AST_CS_RELEASE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctrl_wr && !mode_q[B_AUTO] && reg_wdata[B_REL] |=> flash_sel_n[*2])
    else $error("select not released by strobe");
  AST_CS_ASSERT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctrl_wr && !mode_q[B_AUTO] && reg_wdata[B_ASSERT] && !reg_wdata[B_REL] |=> !flash_sel_n)
    else $error("select not asserted by strobe");
  AST_LANE_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctrl_wr && !mode_q[B_AUTO] && (reg_wdata[2:0] != 3'h0) |=> lane_q ==
    ($past(reg_wdata[B_FOUR]) ? LANE_FOUR : ($past(reg_wdata[B_TWO]) ? LANE_TWO : LANE_ONE)))
    else $error("lane width not set by strobe");
  AST_AUTO_IGNORE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctrl_wr && mode_q[B_AUTO] |=> $stable(lane_q) && $stable(man_cs_n_q))
    else $error("strobe acted in auto mode");
  AST_STROBE_READ: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && (reg_addr == OFF_BUS_CTRL) |=> reg_rdata == 32'h0)
    else $error("bus-control register read not zero");
  AST_MANUAL_MODE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !mode_q[B_AUTO] |-> (flash_sel_n == man_cs_n_q) && !rd_req_ready)
    else $error("manual mode not in control");
  AST_ADDR_LEN: assert property (@(posedge clk_link) disable iff (!lrst_n)
    state_q == S_OUT && $past(state_q) != S_OUT && $stable(cfg_q) |->
    bits_q == (cfg_q[6] ? ADDR_BITS_WIDE : ADDR_BITS_NARROW))
    else $error("wrong address length");
  AST_BURST_HOLD: assert property (@(posedge clk_link) disable iff (!lrst_n)
    word_done && !cfg_q[5] && beats_q > 5'h1 |=> state_q == S_IN && !cs_n_q)
    else $error("burst broken without split");
  AST_SPLIT_BEAT: assert property (@(posedge clk_link) disable iff (!lrst_n)
    word_done && cfg_q[5] && beats_q > 5'h1 |=> state_q == S_END ##16 state_q == S_OUT)
    else $error("split beat not restarted");
  AST_SPLIT_GAP: assert property (@(posedge clk_link) disable iff (!lrst_n)
    state_q == S_END |-> cs_n_q && !sck_q)
    else $error("select low between accesses");
  AST_PIPE_CAP: assert property (@(posedge clk_link) disable iff (!lrst_n)
    cap && cfg_q[1] |-> !sck_q && !first_q && ph_q == {1'b0, cfg_q[4:2]})
    else $error("pipe capture at wrong delay");
  AST_EDGE_CAP: assert property (@(posedge clk_link) disable iff (!lrst_n)
    cap && !cfg_q[1] |-> (sck_q == !cfg_q[0]) && !(cfg_q[0] && first_q))
    else $error("capture on wrong edge");
endmodule

// file: qbm_flash_model.sv
`timescale 1ns/1ps
module qbm_flash_model
  import qbm_pkg::*;
(
  input  wire logic        sck,
  input  wire logic        sel_n,
  input  wire logic        mosi,
  input  wire logic        wide,
  input  wire logic [1:0]  lanes,
  output      logic [3:0]  io,
  output      logic [7:0]  cmd,
  output      logic [31:0] addr,
  output      int          frames
);
  int          edges;
  int          left;
  logic [31:0] cur;
  logic [31:0] sh;
  logic [3:0]  nx;

  initial begin
    io = 4'h0;
    cmd = 8'h00;
    addr = 32'h0;
    frames = 0;
    edges = 0;
    left = 0;
    cur = 32'h0;
    sh = 32'h0;
  end

  // A new selection restarts the header
  always @(negedge sel_n) begin
    edges = 0;
    left = 0;
    addr = 32'h0;
    frames++;
  end

  // Command and address are taken on the rising clock
  always @(posedge sck) begin
    if (!sel_n) begin
      if (edges < 8) begin
        cmd = {cmd[6:0], mosi};
      end else if (edges < (wide ? 40 : 32)) begin
        addr = {addr[30:0], mosi};
        cur = addr;
      end
      edges++;
    end
  end

  // Data launched on the falling clock, held a while past the next one
  always @(negedge sck) begin
    if (!sel_n && edges >= (wide ? 48 : 40)) begin
      if (left == 0) begin
        sh = cur ^ 32'h5a3c_96e1;
        cur = cur + 32'h4;
        left = 32;
      end
      nx = ~io;
      case (lanes)
        LANE_FOUR: begin
          nx = sh[31:28];
          sh = sh << 4;
          left -= 4;
        end
        LANE_TWO: begin
          nx[1:0] = sh[31:30];
          sh = sh << 2;
          left -= 2;
        end
        default: begin
          nx[1] = sh[31];
          sh = sh << 1;
          left -= 1;
        end
      endcase
      io <= #520 nx;
    end
  end

  // Released lines no longer show the last level
  always @(posedge sel_n) begin
    io <= #440 ~io;
  end
endmodule

// file: qbm_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
`define WAITFOR(c, n) begin k = 0; while (!(c) && k < (n)) begin \
  @(negedge clk_sys); k++; end if (!(c)) begin `CHK(1'b0, 1'b1) stop_test(); end end
module qbm_ctrl_tb;
  import qbm_pkg::*;
  logic        clk_sys, clk_link, rst_n, reg_wr, reg_rd;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, rd_req_addr, rd_data, mdl_addr;
  logic        rd_req_valid, rd_req_ready, rd_data_valid, rd_data_ready;
  logic [3:0]  rd_req_len, flash_io_in, flash_io_out, flash_io_oe, mdl_io;
  logic        flash_sel_n, flash_sck, mdl_wide;
  logic [1:0]  mdl_lanes;
  logic [7:0]  mdl_cmd;
  int          frames, errors, checks, k;

  qbm_ctrl #(.FIFO_DEPTH(4)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_link(clk_link), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rd_req_valid(rd_req_valid), .rd_req_ready(rd_req_ready), .rd_req_addr(rd_req_addr),
    .rd_req_len(rd_req_len), .rd_data_valid(rd_data_valid), .rd_data_ready(rd_data_ready),
    .rd_data(rd_data), .flash_sel_n(flash_sel_n), .flash_sck(flash_sck),
    .flash_io_in(flash_io_in), .flash_io_out(flash_io_out), .flash_io_oe(flash_io_oe));

  qbm_flash_model mdl_u (
    .sck(flash_sck), .sel_n(flash_sel_n), .mosi(flash_io_out[0]), .wide(mdl_wide),
    .lanes(mdl_lanes), .io(mdl_io), .cmd(mdl_cmd), .addr(mdl_addr), .frames(frames));

  // Each pin shows whichever side is driving it
  assign flash_io_in = (flash_io_oe & flash_io_out) | (~flash_io_oe & mdl_io);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #17;
    forever #40 clk_link = ~clk_link;
  end

  task automatic stop_test();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  task automatic sc_regs();
    logic [31:0] got;
    rd(OFF_MODE, got);
    `CHK(got, 32'h0000_0000)
    rd(OFF_BUS_CTRL, got);
    `CHK(got, 32'h0000_0000)
    rd(32'h0c00_0008, got);
    `CHK(got, 32'h0000_0000)
    wr(OFF_MODE, 32'hffff_fffe);
    rd(OFF_MODE, got);
    `CHK(got, 32'h0000_3f80)
    wr(OFF_MODE, 32'h0000_0000);
  endtask

  task automatic sc_select();
    logic [31:0] got;
    wr(OFF_BUS_CTRL, 32'h0000_0008);
    `CHK(flash_sel_n, 1'b0)
    wr(OFF_BUS_CTRL, 32'h0000_0000);
    `CHK(flash_sel_n, 1'b0)
    rd(OFF_BUS_CTRL, got);
    `CHK(got, 32'h0000_0000)
    wr(OFF_BUS_CTRL, 32'h0000_0018);
    `CHK(flash_sel_n, 1'b1)
    wr(OFF_BUS_CTRL, 32'h0000_0008);
    wr(OFF_BUS_CTRL, 32'h0000_0010);
    `CHK(flash_sel_n, 1'b1)
  endtask

  task automatic sc_xfer(input logic w, input logic s, input logic p, input logic n,
      input logic [2:0] dl, input logic [31:0] ls, input logic [1:0] lc,
      input logic [31:0] a, input logic [3:0] len, input int hold, input logic ign);
    logic [31:0] m, got, ea;
    int          f0;
    m = 32'h1 | {18'h0, w, s, dl, p, n, 7'h0};
    ea = w ? a : {8'h00, a[23:0]};
    wr(OFF_MODE, 32'h0);
    wr(OFF_BUS_CTRL, ls);
    wr(OFF_MODE, m);
    rd(OFF_MODE, got);
    `CHK(got, m)
    if (ign) begin
      wr(OFF_BUS_CTRL, 32'h0000_000c);
      `CHK(flash_sel_n, 1'b1)
    end
    mdl_wide = w;
    mdl_lanes = lc;
    f0 = frames;
    repeat (30) @(negedge clk_sys);
    `WAITFOR(rd_req_ready === 1'b1, 200)
    rd_req_valid = 1'b1;
    rd_req_addr = a;
    rd_req_len = len;
    @(negedge clk_sys);
    rd_req_valid = 1'b0;
    repeat (hold) @(negedge clk_sys);
    for (int i = 0; i <= int'(len); i++) begin
      `WAITFOR(rd_data_valid === 1'b1, 20000)
      `CHK(rd_data, (ea + 4 * i) ^ 32'h5a3c_96e1)
      rd_data_ready = 1'b1;
      @(negedge clk_sys);
      rd_data_ready = 1'b0;
      @(negedge clk_sys);
    end
    `WAITFOR(rd_req_ready === 1'b1, 2000)
    `CHK(flash_sel_n, 1'b1)
    `CHK(frames - f0, s ? int'(len) + 1 : 1)
    `CHK(mdl_cmd, READ_CMD)
    `CHK(mdl_addr, s ? ea + 4 * len : ea)
  endtask

  initial begin
    errors = 0;
    checks = 0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 32'h0;
    reg_wdata = 32'h0;
    rd_req_valid = 1'b0;
    rd_req_addr = 32'h0;
    rd_req_len = 4'h0;
    rd_data_ready = 1'b0;
    mdl_wide = 1'b0;
    mdl_lanes = LANE_ONE;
    // Held across both clocks so the link side sees it too
    repeat (4) @(posedge clk_link);
    @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (40) @(negedge clk_sys);
    `CHK(flash_sel_n, 1'b1)
    sc_regs();
    sc_select();
    sc_xfer(1'b0, 1'b0, 1'b0, 1'b0, 3'd0, 32'h1, LANE_ONE, 32'h0012_3450, 4'd1, 0, 1'b0);
    sc_xfer(1'b1, 1'b1, 1'b1, 1'b0, 3'd7, 32'h4, LANE_FOUR, 32'hab00_0100, 4'd1, 0, 1'b0);
    sc_xfer(1'b0, 1'b0, 1'b0, 1'b1, 3'd0, 32'h2, LANE_TWO, 32'h7700_0200, 4'd5, 18000, 1'b1);
    sc_xfer(1'b1, 1'b0, 1'b1, 1'b1, 3'd0, 32'h4, LANE_FOUR, 32'h8123_4560, 4'd0, 0, 1'b0);
    stop_test();
  end
endmodule
